// file: rtl/csp_cfg.svh
`ifndef CSP_CFG_SVH
`define CSP_CFG_SVH

// ============================================================
// register addresses carried in the control word
`define CSP_ADDR_NONE      3'h0
`define CSP_ADDR_GAIN      3'h1
`define CSP_ADDR_SHPATH    3'h2
`define CSP_ADDR_PWR       3'h3
`define CSP_ADDR_FASTRT    3'h4
`define CSP_ADDR_SLOWRT    3'h5

// ============================================================
// reset values and masks of bits that exist (others read zero)
`define CSP_RST_GAIN       8'h46
`define CSP_RST_SHPATH     8'h11
`define CSP_RST_PWR        8'h00
`define CSP_RST_FASTRT     8'hf7
`define CSP_RST_SLOWRT     8'h42
`define CSP_USED_GAIN      8'hff
`define CSP_USED_SHPATH    8'hff
`define CSP_USED_PWR       8'hff
`define CSP_USED_FASTRT    8'hff
`define CSP_USED_SLOWRT    8'hff

// ============================================================
// fields of the shift and path control register
`define CSP_SHIFT_HI       4
`define CSP_SHIFT_LO       2
`define CSP_PATH_HI        1
`define CSP_PATH_LO        0

// ============================================================
// frame layout, in bit clock slots
`define CSP_FRAME_BITS     32
`define CSP_LAST_SLOT      5'h1f
`define CSP_SYNC_HIGH      5'h10
`define CSP_PRE_CLKS       4'h8
`define CSP_PRE_PULSE_LO   4'h2
`define CSP_PRE_PULSE_HI   4'h5

// ============================================================
// clock rates and times
`define CSP_REF_HZ         25000000
`define CSP_LINK_HZ        83333333
`define CSP_SCLK_HZ        1280000
`define CSP_VALID_MS       100
`define CSP_DIP_US         44
`define CSP_VALID_CYC      ((`CSP_REF_HZ / 1000) * `CSP_VALID_MS)
`define CSP_DIP_CYC        (((`CSP_REF_HZ / 1000) * `CSP_DIP_US + 999) / 1000)
`define CSP_SCLK_HALF      (`CSP_LINK_HZ / (2 * `CSP_SCLK_HZ))

`endif

// file: rtl/csp_pkg.sv
package csp_pkg;

   // ============================================================
   // user register bank
   typedef struct packed {
      logic [7:0] slowrt;
      logic [7:0] fastrt;
      logic [7:0] pwr;
      logic [7:0] shpath;
      logic [7:0] gain;
   } csp_regs_t;

   // control word, last 12 bits of the incoming frame
   typedef struct packed {
      logic       wr;
      logic [2:0] addr;
      logic [7:0] data;
   } csp_ctrl_t;

   // frame word handed from the link to the system clock
   typedef struct packed {
      logic [19:0] play;
      csp_regs_t   regs;
   } csp_bundle_t;

   // link sequencer, one-hot
   typedef enum logic [2:0] {
      LS_IDLE = 3'b001,
      LS_PRE  = 3'b010,
      LS_RUN  = 3'b100
   } csp_lstate_t;

   // playback path select
   typedef enum logic [1:0] {
      PATH_OFF   = 2'h0,
      PATH_SHIFT = 2'h1,
      PATH_WIDE  = 2'h2,
      PATH_LOOP  = 2'h3
   } csp_path_t;

endpackage

// file: rtl/csp_top.sv
`timescale 1ns/1ps
`include "csp_cfg.svh"

module csp_top #(
   parameter int VALID_CYC = `CSP_VALID_CYC,
   parameter int SCLK_HALF = `CSP_SCLK_HALF
) (
   // system clock and reset
   input  wire logic              REF_CLK_I,
   input  wire logic              RST_N_I,
   // link oscillator
   input  wire logic              LINK_CLK_I,
   // serial pins
   input  wire logic              PROT_SEL_I,
   input  wire logic              SERIAL_DATA_IN_I,
   output logic                   BIT_CLK_O,
   output logic                   FRAME_O,
   output logic                   SERIAL_DATA_OUT_O,
   // supply monitor
   input  wire logic              SUPPLY_OK_I,
   input  wire logic              BAT_LOW_I,
   output logic                   PORT_RUN_O,
   output logic                   MOD_GATE_O,
   // converter side
   input  wire logic [15:0]       CAP_SAMPLE_I,
   input  wire logic              CAP_VALID_I,
   output logic [19:0]            PLAY_SAMPLE_O,
   output logic                   PLAY_VALID_O,
   output csp_pkg::csp_regs_t     CTRL_REGS_O
);

   // ============================================================
   // elaboration checks
   if (SCLK_HALF < 2 || SCLK_HALF > 255) begin : g_bad_half
      $error("SCLK_HALF out of range");
   end
   if (VALID_CYC < 1 || VALID_CYC > 16777215) begin : g_bad_valid
      $error("VALID_CYC out of range");
   end

   localparam logic [7:0]  HALF_M1 = 8'(SCLK_HALF - 1);
   localparam logic [23:0] VALID_C = 24'(VALID_CYC);
   localparam logic [10:0] DIP_C   = 11'(`CSP_DIP_CYC);

   // ============================================================
   // register access helpers
   function automatic logic [7:0] reg_read(input csp_pkg::csp_regs_t r,
                                           input logic [2:0] a);
      logic [7:0] v;
      v = 8'h00;
      if (a == `CSP_ADDR_GAIN) begin
         v = r.gain & `CSP_USED_GAIN;
      end else if (a == `CSP_ADDR_SHPATH) begin
         v = r.shpath & `CSP_USED_SHPATH;
      end else if (a == `CSP_ADDR_PWR) begin
         v = r.pwr & `CSP_USED_PWR;
      end else if (a == `CSP_ADDR_FASTRT) begin
         v = r.fastrt & `CSP_USED_FASTRT;
      end else if (a == `CSP_ADDR_SLOWRT) begin
         v = r.slowrt & `CSP_USED_SLOWRT;
      end
      return v;
   endfunction

   function automatic csp_pkg::csp_regs_t reg_write(
      input csp_pkg::csp_regs_t r, input logic [2:0] a,
      input logic [7:0] d);
      csp_pkg::csp_regs_t n;
      n = r;
      // reserved addresses swallow the write
      if (a == `CSP_ADDR_GAIN) begin
         n.gain = d & `CSP_USED_GAIN;
      end else if (a == `CSP_ADDR_SHPATH) begin
         n.shpath = d & `CSP_USED_SHPATH;
      end else if (a == `CSP_ADDR_PWR) begin
         n.pwr = d & `CSP_USED_PWR;
      end else if (a == `CSP_ADDR_FASTRT) begin
         n.fastrt = d & `CSP_USED_FASTRT;
      end else if (a == `CSP_ADDR_SLOWRT) begin
         n.slowrt = d & `CSP_USED_SLOWRT;
      end
      return n;
   endfunction

   // 16-bit sample placed in the 20-bit playback word
   function automatic logic [19:0] shift_sample(input logic [15:0] s,
                                                input logic [2:0] sh);
      logic [19:0] w;
      logic [15:0] c;
      w = {{4{s[15]}}, s};
      c = s;
      if (sh >= 3'h5) begin
         // clamp to 15-bit signed so five bits fit without wrap
         if (!s[15] && s[14]) begin
            c = 16'h3fff;
         end else if (s[15] && !s[14]) begin
            c = 16'hc000;
         end
         w = {c[14:0], 5'h00};
      end else begin
         w = w << sh;
      end
      return w;
   endfunction

   // ============================================================
   // reset synchronisers, async assert and clocked release
   logic [1:0] rrst_q;
   logic [1:0] lrst_q;
   logic       rrst_n;
   logic       lrst_n;

   always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) rrst_q <= 2'h0;
      else          rrst_q <= {rrst_q[0], 1'b1};
   end
   always_ff @(posedge LINK_CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) lrst_q <= 2'h0;
      else          lrst_q <= {lrst_q[0], 1'b1};
   end
   assign rrst_n = rrst_q[1];
   assign lrst_n = lrst_q[1];

   // ============================================================
   // system side: supply qualification
   logic        sup_s1_q, sup_s2_q, bat_s1_q, bat_s2_q;
   logic [23:0] valid_cnt_q;
   logic [10:0] dip_cnt_q;
   logic        run_q;

   always_ff @(posedge REF_CLK_I or negedge rrst_n) begin
      if (!rrst_n) begin
         sup_s1_q <= 1'b0;
         sup_s2_q <= 1'b0;
         bat_s1_q <= 1'b0;
         bat_s2_q <= 1'b0;
      end else begin
         sup_s1_q <= SUPPLY_OK_I;
         sup_s2_q <= sup_s1_q;
         bat_s1_q <= BAT_LOW_I;
         bat_s2_q <= bat_s1_q;
      end
   end

   // bounce restarts the count; once running it stays running
   always_ff @(posedge REF_CLK_I or negedge rrst_n) begin
      if (!rrst_n) begin
         valid_cnt_q <= 24'h000000;
         run_q       <= 1'b0;
      end else if (!run_q) begin
         if (!sup_s2_q) begin
            valid_cnt_q <= 24'h000000;
         end else if (valid_cnt_q == VALID_C - 24'h000001) begin
            run_q <= 1'b1;
         end else begin
            valid_cnt_q <= valid_cnt_q + 24'h000001;
         end
      end
   end

   // dips shorter than the limit never reach the gate
   always_ff @(posedge REF_CLK_I or negedge rrst_n) begin
      if (!rrst_n) begin
         dip_cnt_q <= 11'h000;
      end else if (!bat_s2_q) begin
         dip_cnt_q <= 11'h000;
      end else if (dip_cnt_q != DIP_C) begin
         dip_cnt_q <= dip_cnt_q + 11'h001;
      end
   end

   always_ff @(posedge REF_CLK_I or negedge rrst_n) begin
      if (!rrst_n) begin
         PORT_RUN_O <= 1'b0;
         MOD_GATE_O <= 1'b1;
      end else begin
         PORT_RUN_O <= run_q;
         MOD_GATE_O <= !run_q || (dip_cnt_q == DIP_C);
      end
   end

   // ============================================================
   // system side: capture word toward the link
   logic [15:0] cap_q;
   logic        ctog_q;

   // word is held stable while the link copies it after the toggle
   always_ff @(posedge REF_CLK_I or negedge rrst_n) begin
      if (!rrst_n) begin
         cap_q  <= 16'h0000;
         ctog_q <= 1'b0;
      end else if (CAP_VALID_I) begin
         cap_q  <= CAP_SAMPLE_I;
         ctog_q <= !ctog_q;
      end
   end

   // ============================================================
   // link side: pin and crossing synchronisers
   logic prot_s1_q, prot_s2_q, rxdi_s1_q, rxdi_s2_q;
   logic run_s1_q, run_s2_q, ct_s1_q, ct_s2_q, ct_s3_q;

   always_ff @(posedge LINK_CLK_I or negedge lrst_n) begin
      if (!lrst_n) begin
         prot_s1_q <= 1'b0;
         prot_s2_q <= 1'b0;
         rxdi_s1_q <= 1'b0;
         rxdi_s2_q <= 1'b0;
         run_s1_q  <= 1'b0;
         run_s2_q  <= 1'b0;
         ct_s1_q   <= 1'b0;
         ct_s2_q   <= 1'b0;
         ct_s3_q   <= 1'b0;
      end else begin
         prot_s1_q <= PROT_SEL_I;
         prot_s2_q <= prot_s1_q;
         rxdi_s1_q <= SERIAL_DATA_IN_I;
         rxdi_s2_q <= rxdi_s1_q;
         run_s1_q  <= run_q;
         run_s2_q  <= run_s1_q;
         ct_s1_q   <= ctog_q;
         ct_s2_q   <= ct_s1_q;
         ct_s3_q   <= ct_s2_q;
      end
   end

   logic [15:0] cap_l_q;

   always_ff @(posedge LINK_CLK_I or negedge lrst_n) begin
      if (!lrst_n)                 cap_l_q <= 16'h0000;
      else if (ct_s2_q != ct_s3_q) cap_l_q <= cap_q;
   end

   // ============================================================
   // link side: bit clock divider
   csp_pkg::csp_lstate_t state_q;
   logic [7:0]           div_q;
   logic                 sclk_q;
   logic                 tick, rise, fall;

   assign tick = (div_q == HALF_M1) && (state_q != csp_pkg::LS_IDLE);
   assign rise = tick && !sclk_q;
   assign fall = tick && sclk_q;

   always_ff @(posedge LINK_CLK_I or negedge lrst_n) begin
      if (!lrst_n) begin
         div_q  <= 8'h00;
         sclk_q <= 1'b0;
      end else if (state_q == csp_pkg::LS_IDLE) begin
         div_q  <= 8'h00;
         sclk_q <= 1'b0;
      end else if (div_q == HALF_M1) begin
         div_q  <= 8'h00;
         sclk_q <= !sclk_q;
      end else begin
         div_q <= div_q + 8'h01;
      end
   end

   // ============================================================
   // link side: sequencer, slot counter and frame pin
   logic       spi_q;
   logic [3:0] pre_q;
   logic [4:0] slot_q;
   logic       live_q;
   logic       frame_q;
   logic       frame_end;

   assign frame_end = fall && (slot_q == `CSP_LAST_SLOT);

   always_ff @(posedge LINK_CLK_I or negedge lrst_n) begin
      if (!lrst_n) begin
         state_q <= csp_pkg::LS_IDLE;
         spi_q   <= 1'b0;
         pre_q   <= 4'h0;
         slot_q  <= `CSP_LAST_SLOT;
         live_q  <= 1'b0;
         frame_q <= 1'b0;
      end else begin
         case (state_q)
            csp_pkg::LS_IDLE: begin
               frame_q <= 1'b0;
               live_q  <= 1'b0;
               slot_q  <= `CSP_LAST_SLOT;
               pre_q   <= 4'h0;
               if (run_s2_q) begin
                  spi_q   <= prot_s2_q;
                  state_q <= prot_s2_q ? csp_pkg::LS_PRE
                                       : csp_pkg::LS_RUN;
               end
            end
            csp_pkg::LS_PRE: begin
               if (fall) begin
                  pre_q   <= pre_q + 4'h1;
                  // slave reset pulse inside the silent clocks
                  frame_q <= (pre_q >= `CSP_PRE_PULSE_LO) &&
                             (pre_q <= `CSP_PRE_PULSE_HI);
                  if (pre_q == `CSP_PRE_CLKS - 4'h1) begin
                     frame_q <= 1'b0;
                     state_q <= csp_pkg::LS_RUN;
                  end
               end
            end
            csp_pkg::LS_RUN: begin
               if (frame_end && (prot_s2_q != spi_q)) begin
                  // mode changes only at a frame boundary
                  state_q <= csp_pkg::LS_IDLE;
               end else if (fall) begin
                  slot_q  <= slot_q + 5'h01;
                  live_q  <= live_q | frame_end;
                  // frame mode: high first half; SPI: select held low
                  frame_q <= spi_q ? 1'b0 :
                             ((slot_q + 5'h01) < `CSP_SYNC_HIGH);
               end
            end
            default: state_q <= csp_pkg::LS_IDLE;
         endcase
      end
   end

   // ============================================================
   // link side: receive shifter, sampled on the rising edge
   logic [31:0] rx_q;
   logic [31:0] rx_word;

   always_ff @(posedge LINK_CLK_I or negedge lrst_n) begin
      if (!lrst_n)   rx_q <= 32'h00000000;
      else if (rise) rx_q <= {rx_q[30:0], rxdi_s2_q};
   end
   // word is complete once the last slot has been sampled
   assign rx_word = rx_q;

   // ============================================================
   // link side: transmit shifter, launched on the falling edge
   logic [23:0] tx_q;
   logic [7:0]  resp_now;
   logic        txbit_q;

   always_ff @(posedge LINK_CLK_I or negedge lrst_n) begin
      if (!lrst_n) begin
         tx_q    <= 24'h000000;
         txbit_q <= 1'b0;
      end else if (state_q != csp_pkg::LS_RUN) begin
         tx_q    <= 24'h000000;
         txbit_q <= 1'b0;
      end else if (frame_end) begin
         tx_q    <= {cap_l_q, resp_now};
         txbit_q <= cap_l_q[15];
      end else if (fall) begin
         tx_q    <= {tx_q[22:0], 1'b0};
         txbit_q <= tx_q[22];
      end
   end

   // ============================================================
   // link side: control word handling at frame end
   csp_pkg::csp_regs_t regs_q;
   csp_pkg::csp_ctrl_t ctl;
   logic               pend_q;
   logic               pend_wr_q;
   logic [2:0]         pend_a_q;
   logic [19:0]        play_l_q;

   assign ctl = csp_pkg::csp_ctrl_t'(rx_word[11:0]);

   // answer leaves in the frame that starts at this same edge
   assign resp_now = (live_q && !(spi_q && pend_q) && !ctl.wr &&
                      (ctl.addr != `CSP_ADDR_NONE)) ?
                     reg_read(regs_q, ctl.addr) : 8'h00;

   always_ff @(posedge LINK_CLK_I or negedge lrst_n) begin
      if (!lrst_n) begin
         regs_q    <= {`CSP_RST_SLOWRT, `CSP_RST_FASTRT, `CSP_RST_PWR,
                       `CSP_RST_SHPATH, `CSP_RST_GAIN};
         pend_q    <= 1'b0;
         pend_wr_q <= 1'b0;
         pend_a_q  <= 3'h0;
         play_l_q  <= 20'h00000;
      end else if (state_q != csp_pkg::LS_RUN) begin
         pend_q <= 1'b0;
      end else if (frame_end && live_q) begin
         play_l_q <= rx_word[31:12];
         if (spi_q && pend_q) begin
            // second frame: data taken, address field ignored
            pend_q <= 1'b0;
            if (pend_wr_q) begin
               regs_q <= reg_write(regs_q, pend_a_q, ctl.data);
            end
         end else if (ctl.addr != `CSP_ADDR_NONE) begin
            if (spi_q) begin
               pend_q    <= 1'b1;
               pend_wr_q <= ctl.wr;
               pend_a_q  <= ctl.addr;
            end else if (ctl.wr) begin
               regs_q <= reg_write(regs_q, ctl.addr, ctl.data);
            end
         end
         // address zero: audio only, direction bit ignored
      end
   end

   // ============================================================
   // link side: pins and handoff toward the system clock
   csp_pkg::csp_bundle_t bundle_q;
   logic                 ltog_q;
   logic                 fe_q;

   always_ff @(posedge LINK_CLK_I or negedge lrst_n) begin
      if (!lrst_n) begin
         BIT_CLK_O         <= 1'b0;
         FRAME_O           <= 1'b0;
         SERIAL_DATA_OUT_O <= 1'b0;
      end else begin
         BIT_CLK_O         <= sclk_q;
         FRAME_O           <= frame_q;
         SERIAL_DATA_OUT_O <= txbit_q;
      end
   end

   // bundle is held for a whole frame, far longer than the sync;
   // taken a cycle late so this frame's sample and write are in it
   always_ff @(posedge LINK_CLK_I or negedge lrst_n) begin
      if (!lrst_n) begin
         bundle_q <= '0;
         ltog_q   <= 1'b0;
         fe_q     <= 1'b0;
      end else begin
         fe_q <= frame_end && live_q && (state_q == csp_pkg::LS_RUN);
         if (fe_q) begin
            bundle_q <= {play_l_q, regs_q};
            ltog_q   <= !ltog_q;
         end
      end
   end

   // ============================================================
   // system side: playback path
   logic       lt_s1_q, lt_s2_q, lt_s3_q;
   logic [2:0] sh;
   logic [1:0] path;
   logic [19:0] play_d;

   always_ff @(posedge REF_CLK_I or negedge rrst_n) begin
      if (!rrst_n) begin
         lt_s1_q <= 1'b0;
         lt_s2_q <= 1'b0;
         lt_s3_q <= 1'b0;
      end else begin
         lt_s1_q <= ltog_q;
         lt_s2_q <= lt_s1_q;
         lt_s3_q <= lt_s2_q;
      end
   end

   assign sh   = bundle_q.regs.shpath[`CSP_SHIFT_HI:`CSP_SHIFT_LO];
   assign path = bundle_q.regs.shpath[`CSP_PATH_HI:`CSP_PATH_LO];

   always_comb begin
      play_d = 20'h00000;
      if (path == csp_pkg::PATH_SHIFT) begin
         play_d = shift_sample(bundle_q.play[19:4], sh);
      end else if (path == csp_pkg::PATH_WIDE) begin
         play_d = bundle_q.play;
      end else if (path == csp_pkg::PATH_LOOP) begin
         play_d = shift_sample(cap_q, sh);
      end
   end

   always_ff @(posedge REF_CLK_I or negedge rrst_n) begin
      if (!rrst_n) begin
         PLAY_SAMPLE_O <= 20'h00000;
         PLAY_VALID_O  <= 1'b0;
         CTRL_REGS_O   <= {`CSP_RST_SLOWRT, `CSP_RST_FASTRT, `CSP_RST_PWR,
                           `CSP_RST_SHPATH, `CSP_RST_GAIN};
      end else begin
         PLAY_VALID_O <= lt_s2_q != lt_s3_q;
         if (lt_s2_q != lt_s3_q) begin
            CTRL_REGS_O   <= bundle_q.regs;
            PLAY_SAMPLE_O <= MOD_GATE_O ? 20'h00000 : play_d;
         end
      end
   end

endmodule

// file: verification/csp_top_monitor.sv
`timescale 1ns/1ps
// ============================================================
// port checker
module csp_top_monitor #(
   parameter int VALID_CYC = 20,
   parameter int SCLK_HALF = 4
) (
   // clocks and reset
   input wire logic               REF_CLK_I,
   input wire logic               RST_N_I,
   input wire logic               LINK_CLK_I,
   // serial pins
   input wire logic               PROT_SEL_I,
   input wire logic               BIT_CLK_O,
   input wire logic               FRAME_O,
   input wire logic               SERIAL_DATA_OUT_O,
   // supply and playback
   input wire logic               SUPPLY_OK_I,
   input wire logic               BAT_LOW_I,
   input wire logic               PORT_RUN_O,
   input wire logic               MOD_GATE_O,
   input wire logic               PLAY_VALID_O,
   input wire csp_pkg::csp_regs_t CTRL_REGS_O
);
   int hc_q, rc_q, sc_q, bc_q;

   // link side: cycles per clock level, rises per frame level
   always_ff @(posedge LINK_CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         hc_q <= 0;
         rc_q <= 0;
      end else begin
         hc_q <= $changed(BIT_CLK_O) ? 1 : hc_q + 1;
         rc_q <= $changed(FRAME_O) ? 0 : rc_q + int'($rose(BIT_CLK_O));
      end
   end

   // supply side: length of the present high run of each monitor
   always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         sc_q <= 0;
         bc_q <= 0;
      end else begin
         sc_q <= SUPPLY_OK_I ? sc_q + 1 : 0;
         bc_q <= BAT_LOW_I ? bc_q + 1 : 0;
      end
   end

   // ============================================================
   // link timing; the low level before the first frame after idle has one rise only
   AST_HALF: assert property (
      @(posedge LINK_CLK_I) disable iff (!RST_N_I) $fell(BIT_CLK_O)
      |-> hc_q == SCLK_HALF) else $error("bit clock high time off");
   AST_DUTY: assert property (
      @(posedge LINK_CLK_I) disable iff (!RST_N_I)
      $changed(FRAME_O) && !PROT_SEL_I |-> rc_q == 16 || rc_q <= 1 && FRAME_O)
      else $error("frame level not 16 bits");
   AST_SDO: assert property (
      @(posedge LINK_CLK_I) disable iff (!RST_N_I) $changed(SERIAL_DATA_OUT_O)
      |-> !BIT_CLK_O) else $error("data moved while clock high");
   AST_IDLE: assert property (
      @(posedge LINK_CLK_I) disable iff (!RST_N_I) !PORT_RUN_O
      |-> !BIT_CLK_O && !FRAME_O) else $error("link active before start");
   // ============================================================
   // supply and register timing
   AST_START: assert property (
      @(posedge REF_CLK_I) disable iff (!RST_N_I) $rose(PORT_RUN_O)
      |-> sc_q >= VALID_CYC) else $error("start too early");
   AST_GATE: assert property (
      @(posedge REF_CLK_I) disable iff (!RST_N_I) !PORT_RUN_O
      |-> MOD_GATE_O) else $error("playback open before start");
   AST_DIP: assert property (
      @(posedge REF_CLK_I) disable iff (!RST_N_I) bc_q > 1110
      |-> MOD_GATE_O) else $error("long dip not gated");
   AST_REGS: assert property (
      @(posedge REF_CLK_I) disable iff (!RST_N_I) $changed(CTRL_REGS_O)
      |-> PLAY_VALID_O) else $error("register moved mid frame");
endmodule

bind csp_top csp_top_monitor #(.VALID_CYC(VALID_CYC), .SCLK_HALF(SCLK_HALF))
   i_mon (.REF_CLK_I(REF_CLK_I), .RST_N_I(RST_N_I), .LINK_CLK_I(LINK_CLK_I),
   .PROT_SEL_I(PROT_SEL_I), .BIT_CLK_O(BIT_CLK_O), .FRAME_O(FRAME_O),
   .SERIAL_DATA_OUT_O(SERIAL_DATA_OUT_O), .SUPPLY_OK_I(SUPPLY_OK_I),
   .BAT_LOW_I(BAT_LOW_I), .PORT_RUN_O(PORT_RUN_O), .MOD_GATE_O(MOD_GATE_O),
   .PLAY_VALID_O(PLAY_VALID_O), .CTRL_REGS_O(CTRL_REGS_O));

// file: verification/csp_host_model.sv
`timescale 1ns/1ps
// ============================================================
// host serial port, frame protocol
module csp_host_model (
   // pins
   input  wire logic        bit_clk_i,
   input  wire logic        frame_i,
   input  wire logic        sdo_i,
   output logic             sdi_o,
   // frame words
   input  wire logic [31:0] tx_i,
   output logic [31:0]      rx_o
);
   logic [31:0] cur = '0;
   logic [31:0] sh = '0;
   logic        fprev = 1'b0;
   int          idx = 0;

   initial sdi_o = 1'b0;
   initial rx_o = '0;

   // rising clock: sample, resync on frame start (frame is settled here)
   always @(posedge bit_clk_i) begin
      sh <= {sh[30:0], sdo_i};
      fprev <= frame_i;
      if (frame_i && !fprev) begin
         rx_o <= sh;
         idx = 1;
      end
   end

   // falling clock: launch next bit, new word at slot 0
   always @(negedge bit_clk_i) begin
      if (idx >= 32) idx = 0;
      if (idx == 0) cur = tx_i;
      sdi_o <= cur[31 - idx];
      idx = idx + 1;
   end
endmodule

// file: verification/testbench.sv
`timescale 1ns/1ps
// ============================================================
// bench for the serial audio control port
module testbench;
   localparam int VC = 20;
   logic clk = 1'b0, lclk = 1'b0, rst_n, psel, sdi, bclk, frm, sdo;
   logic sok, blow, run, gate, capv, pv;
   logic [15:0] cap;
   logic [19:0] play;
   logic [31:0] tx, rx;
   logic [7:0]  ex [8];
   logic [47:0] tab [8];
   csp_pkg::csp_regs_t regs;
   int err_count = 0, n_compared = 0, nr = 0, nh = 0, n;

   // clocks: link period 12 ns, offset from the system clock
   always #20 clk = ~clk;
   initial begin
      #2.5;
      forever #6 lclk = ~lclk;
   end
   // bit clock rises, and frame level seen at each
   always @(posedge bclk) begin
      nr++;
      nh += int'(frm);
   end

   csp_top #(.VALID_CYC(VC), .SCLK_HALF(4)) i_csp_top (
      .REF_CLK_I(clk), .RST_N_I(rst_n), .LINK_CLK_I(lclk),
      .PROT_SEL_I(psel), .SERIAL_DATA_IN_I(sdi), .BIT_CLK_O(bclk),
      .FRAME_O(frm), .SERIAL_DATA_OUT_O(sdo), .SUPPLY_OK_I(sok),
      .BAT_LOW_I(blow), .PORT_RUN_O(run), .MOD_GATE_O(gate),
      .CAP_SAMPLE_I(cap), .CAP_VALID_I(capv), .PLAY_SAMPLE_O(play),
      .PLAY_VALID_O(pv), .CTRL_REGS_O(regs));
   csp_host_model i_csp_host_model (.bit_clk_i(bclk), .frame_i(frm),
      .sdo_i(sdo), .sdi_o(sdi), .tx_i(tx), .rx_o(rx));

   task automatic report_and_stop();
      $display("compared %0d mismatched %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic chk(input logic [39:0] g, input logic [39:0] e);
      n_compared++;
      if (g !== e) begin
         err_count++;
         $display("unexpected at %0t: got %h exp %h", $time, g, e);
      end
   endtask
   // bounded wait: for a playback pulse, or for the port to start
   task automatic waitfor(input bit for_run, output int k);
      k = 0;
      do begin
         @(posedge clk);
         k++;
      end while ((for_run ? run : pv) !== 1'b1 && k < 500);
      if (k >= 500) begin
         err_count++;
         report_and_stop();
      end
   endtask
   // one word per call; a word goes out in the next two frames
   task automatic xfer(input logic [31:0] w);
      tx <= w;
      repeat (2) waitfor(1'b0, n);
   endtask

   initial begin
      {rst_n, psel, sok, blow, capv} = '0;
      cap = '0;
      tx = '0;
      ex = '{8'h00, 8'h46, 8'h11, 8'h00, 8'hf7, 8'h42, 8'h00, 8'h00};
      tab = '{{8'h12, 20'habcde, 20'habcde}, {8'h11, 20'h12345, 20'h12340},
         {8'h15, 20'h7fff0, 20'h7ffe0}, {8'h15, 20'h80000, 20'h80000},
         {8'h01, 20'h12345, 20'h01234}, {8'h10, 20'h12345, 20'h00000},
         {8'h1d, 20'h01230, 20'h02460}, {8'h13, 20'h00000, 20'h0a5c0}};
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      repeat (40) @(posedge clk);
      chk(regs, {ex[5], ex[4], ex[3], ex[2], ex[1]});
      chk({run, gate}, 2'b01);
      sok <= 1'b1;
      waitfor(1'b1, n);
      chk(n >= VC && n < VC + 8, 1'b1);
      $display("end start");
      // writes to every address, reserved and audio-only among them
      repeat (2) xfer('0);
      for (int a = 0; a < 8; a++) begin
         xfer({20'h0, 1'b1, a[2:0], 8'h21 * a[7:0] + 8'h0e});
         if (a > 0 && a < 6) ex[a] = 8'h21 * a[7:0] + 8'h0e;
      end
      chk(regs, {ex[5], ex[4], ex[3], ex[2], ex[1]});
      // reads: each answer comes one frame later
      for (int a = 1; a < 9; a++) begin
         xfer({20'h0, 1'b0, a[2:0], 8'hff});
         if (a > 1) chk(rx[15:0], {ex[a - 1], 8'h00});
      end
      $display("end registers");
      @(posedge clk);
      cap <= 16'h0a5c;
      capv <= 1'b1;
      @(posedge clk);
      capv <= 1'b0;
      xfer('0);
      chk(rx[31:16], 16'h0a5c);
      // path and shift settings, each followed by a playback word
      foreach (tab[i]) begin
         xfer({20'h0, 4'ha, tab[i][47:40]});
         xfer({tab[i][39:20], 12'h000});
         chk(play, tab[i][19:0]);
      end
      $display("end playback");
      blow <= 1'b1;
      repeat (200) @(posedge clk);
      blow <= 1'b0;
      repeat (10) @(posedge clk);
      chk(gate, 1'b0);
      blow <= 1'b1;
      repeat (1200) @(posedge clk);
      chk(gate, 1'b1);
      blow <= 1'b0;
      $display("end supply");
      // second reset into the other protocol
      rst_n <= 1'b0;
      psel <= 1'b1;
      repeat (12) @(posedge clk);
      nr = 0;
      nh = 0;
      rst_n <= 1'b1;
      waitfor(1'b1, n);
      repeat (300) @(posedge clk);
      chk(nh, 4);
      chk(nr > 100, 1'b1);
      $display("end select");
      report_and_stop();
   end
endmodule
